// ### sar_adc_control.sv
// Register file and control for the four-input 8-bit converter.
// Assumes register port and sleep/trigger inputs come from sys_clk logic.
//
// Notes on behaviour
// - Successive approximation of held input, 8 bits
// - Reference is supply or external reference pin
// - Converts in sleep only on RC clock
// - Reset clears registers, aborts any conversion
// - Bits 7-6 pick conversion clock divider
// - Bits 5-3 pick channel, 1xx reserved
// - Enable bit0, start bit2, bit1 reads zero
// - Pin register sets analog pins, reference pin
// - Done loads result, clears start, flags
// - Conversion lasts nine and half periods, longer on the divide-by-2 clock
// - Compare trigger starts only when enabled
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // System
  input wire logic device_sleep,
  input wire logic [3:0] compare_mode_select,
  input wire logic special_event_trigger,
  // Analog front end
  input wire logic comparator_out,
  input wire logic rc_osc_in,
  output logic [7:0] dac_code,
  output logic sample_hold_open,
  output logic [2:0] input_channel_select,
  output logic ref_external_sel,
  output logic [3:0] analog_pin_enable,
  // Status
  output logic converter_on,
  output logic conversion_done_flag,
  output logic conversion_done_pulse
);
  import sar_adc_pkg::*;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [2:0] chan;
    logic go;
    logic on;
    logic [2:0] pincfg;
    logic [7:0] result;
    logic done_flag;
    logic done_pulse;
    logic start;
    logic [7:0] rdata;
    logic [2:0] chan_out;
    logic ref_ext;
    logic [3:0] pin_en;
  } ctrl_t;

  ctrl_t s_reg;
  ctrl_t s_next;

  logic half_tick;
  logic tick_run;
  logic eng_busy;
  logic eng_done;
  logic [7:0] eng_result;

  // Pin layout: bit 4 is the reference select, bits 3-0 the analog pins
  function automatic logic [4:0] pin_decode(input logic [2:0] cfg);
    unique case (cfg)
      3'h0: pin_decode = 5'b0_1111;
      3'h1: pin_decode = 5'b1_0111;
      3'h2: pin_decode = 5'b0_0011;
      3'h3: pin_decode = 5'b1_0011;
      3'h4: pin_decode = 5'b0_0001;
      3'h5: pin_decode = 5'b1_0001;
      default: pin_decode = 5'b0_0000;
    endcase
  endfunction : pin_decode

  function automatic logic [7:0] ctrl_image(input ctrl_t c);
    ctrl_image = 8'h00;
    ctrl_image[CLKSEL_LSB +: 2] = c.clk_sel;
    ctrl_image[CHAN_LSB +: 3] = c.chan;
    ctrl_image[GO_BIT] = c.go;
    ctrl_image[ON_BIT] = c.on;
  endfunction : ctrl_image

  // Clock keeps running in sleep only when the RC source is chosen
  assign tick_run = eng_busy && (!device_sleep || s_reg.clk_sel == CLK_RC);

  adc_clock_tick u_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_sel(s_reg.clk_sel),
    .run(tick_run),
    .rc_osc_in(rc_osc_in),
    .half_tick(half_tick)
  );

  sar_engine u_engine (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(s_reg.start),
    .abort(!s_reg.go),
    .half_tick(half_tick),
    .comparator_out(comparator_out),
    .dac_code(dac_code),
    .sample_hold_open(sample_hold_open),
    .busy(eng_busy),
    .done(eng_done),
    .result(eng_result)
  );

  always_comb begin
    logic [4:0] pin_map;
    pin_map = 5'h00;
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.done_pulse = 1'b0;
    s_next.rdata = 8'h00;

    if (reg_rd) begin
      unique case (reg_addr)
        CTRL_ADDR: s_next.rdata = ctrl_image(s_reg);
        RESULT_ADDR: s_next.rdata = s_reg.result;
        PINCFG_ADDR: s_next.rdata = {5'h00, s_reg.pincfg};
        FLAG_ADDR: s_next.rdata = {1'b0, s_reg.done_flag, 6'h00};
        default: s_next.rdata = 8'h00;
      endcase
    end

    if (reg_wr) begin
      unique case (reg_addr)
        CTRL_ADDR: begin
          s_next.clk_sel = reg_wdata[CLKSEL_LSB +: 2];
          // Reserved channel codes are stored but drive channel 0 onto the select output
          s_next.chan = reg_wdata[CHAN_LSB +: 3];
          s_next.on = reg_wdata[ON_BIT];
          // Enable must already be set before the start bit counts
          if (reg_wdata[GO_BIT] && s_reg.on && !s_reg.go) begin
            s_next.go = 1'b1;
            s_next.start = 1'b1;
          end else if (!reg_wdata[GO_BIT]) begin
            s_next.go = 1'b0;
          end
        end
        PINCFG_ADDR: s_next.pincfg = reg_wdata[2:0];
        FLAG_ADDR: s_next.done_flag = reg_wdata[DONE_FLAG_BIT];
        default: begin
        end
      endcase
    end

    if (special_event_trigger && compare_mode_select == TRIGGER_MODE && s_reg.on
        && !s_reg.go) begin
      s_next.go = 1'b1;
      s_next.start = 1'b1;
    end

    // Switching the module off aborts whatever is running
    if (!s_next.on) begin
      s_next.go = 1'b0;
      s_next.start = 1'b0;
    end

    // Placed last so a completing conversion beats a software clear
    if (eng_done && s_reg.go) begin
      s_next.result = eng_result;
      s_next.go = 1'b0;
      s_next.done_flag = 1'b1;
      s_next.done_pulse = 1'b1;
    end

    s_next.chan_out = s_next.chan[2] ? 3'h0 : s_next.chan;
    pin_map = pin_decode(s_next.pincfg);
    s_next.ref_ext = pin_map[4];
    s_next.pin_en = pin_map[3:0];
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_reg <= '{
        clk_sel: CLKSEL_RESET,
        chan: CHAN_RESET,
        pincfg: PINCFG_RESET,
        result: RESULT_RESET,
        chan_out: CHAN_RESET,
        pin_en: 4'hF,
        default: '0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign input_channel_select = s_reg.chan_out;
  assign ref_external_sel = s_reg.ref_ext;
  assign analog_pin_enable = s_reg.pin_en;
  assign converter_on = s_reg.on;
  assign conversion_done_flag = s_reg.done_flag;
  assign conversion_done_pulse = s_reg.done_pulse;

endmodule : sar_adc_control
`default_nettype wire

// ### sar_adc_pkg.sv
// Constants and types shared by the converter control block.
// Assumes one system clock at 100 MHz and a synchronous, active-low reset.
package sar_adc_pkg;

  // Register map, byte addresses on the plain register port
  localparam logic [7:0] CTRL_ADDR = 8'h1F;
  localparam logic [7:0] RESULT_ADDR = 8'h1E;
  localparam logic [7:0] PINCFG_ADDR = 8'h9F;
  localparam logic [7:0] FLAG_ADDR = 8'h0C;

  // Control register fields
  localparam int CLKSEL_LSB = 6;
  localparam int CHAN_LSB = 3;
  localparam int GO_BIT = 2;
  localparam int ON_BIT = 0;

  // Flag register field
  localparam int DONE_FLAG_BIT = 6;

  // Reset values
  localparam logic [1:0] CLKSEL_RESET = 2'h0;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [2:0] PINCFG_RESET = 3'h0;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Conversion clock codes
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC = 2'h3;

  // Half bit-period lengths in system clocks for each divider
  localparam logic [4:0] HALF_DIV2 = 5'h01;
  localparam logic [4:0] HALF_DIV8 = 5'h04;
  localparam logic [4:0] HALF_DIV32 = 5'h10;

  // Conversion timing in half bit-periods: 2 setup, 16 for bits, 1 to load
  localparam logic [4:0] SETUP_HALVES = 5'h02;
  localparam logic [4:0] CONV_HALVES = 5'h13;

  // Clocks a new trial code needs to pass the comparator synchroniser
  localparam logic [2:0] SETTLE_CLKS = 3'h4;

  // Compare mode that routes the special event trigger to the converter
  localparam logic [3:0] TRIGGER_MODE = 4'hB;

  typedef enum logic [3:0] {
    ENG_IDLE = 4'b0001,
    ENG_SETUP = 4'b0010,
    ENG_CONVERT = 4'b0100,
    ENG_FINISH = 4'b1000
  } eng_state_t;

endpackage : sar_adc_pkg

// ### adc_clock_tick.sv
// Half bit-period tick generator for the converter.
// Assumes rc_osc_in is an unsynchronised square wave from the RC oscillator.
`timescale 1ns/1ns
`default_nettype none
module adc_clock_tick (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control
  input wire logic [1:0] clk_sel,
  input wire logic run,
  // RC oscillator
  input wire logic rc_osc_in,
  // Tick
  output logic half_tick
);
  import sar_adc_pkg::*;

  typedef struct packed {
    logic [2:0] rc_sync;
    logic rc_level;
    logic [4:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t s_reg;
  tick_state_t s_next;

  function automatic logic [4:0] half_len(input logic [1:0] sel);
    unique case (sel)
      CLK_DIV2: half_len = HALF_DIV2;
      CLK_DIV8: half_len = HALF_DIV8;
      default: half_len = HALF_DIV32;
    endcase
  endfunction : half_len

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    s_next.rc_sync = {s_reg.rc_sync[1:0], rc_osc_in};
    // Level changes only once the later two stages agree
    if (s_reg.rc_sync[1] == s_reg.rc_sync[2]) begin
      s_next.rc_level = s_reg.rc_sync[2];
    end
    if (!run) begin
      s_next.cnt = 5'h00;
    end else if (clk_sel == CLK_RC) begin
      // Both oscillator edges mark half periods
      s_next.tick = s_next.rc_level != s_reg.rc_level;
    end else if (s_reg.cnt == half_len(clk_sel) - 5'h01) begin
      s_next.cnt = 5'h00;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign half_tick = s_reg.tick;

endmodule : adc_clock_tick
`default_nettype wire

// ### sar_engine.sv
// Successive approximation sequencer driving the trial code of the DAC.
// Assumes comparator_out is high while the held input is at or above the trial level.
`timescale 1ns/1ns
`default_nettype none
module sar_engine (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic half_tick,
  // Analog side
  input wire logic comparator_out,
  output logic [7:0] dac_code,
  output logic sample_hold_open,
  // Status
  output logic busy,
  output logic done,
  output logic [7:0] result
);
  import sar_adc_pkg::*;

  typedef struct packed {
    eng_state_t state;
    logic [4:0] half;
    logic [2:0] bit_idx;
    logic [7:0] dac;
    logic [7:0] result;
    logic hold;
    logic done;
    logic [2:0] cmp_sync;
    logic cmp_level;
    logic [2:0] settle;
  } eng_t;

  eng_t s_reg;
  eng_t s_next;

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction : bit_mask

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.cmp_sync = {s_reg.cmp_sync[1:0], comparator_out};
    if (s_reg.cmp_sync[1] == s_reg.cmp_sync[2]) begin
      s_next.cmp_level = s_reg.cmp_sync[2];
    end
    if (abort && s_reg.state != ENG_IDLE) begin
      s_next.state = ENG_IDLE;
      s_next.hold = 1'b0;
      s_next.dac = 8'h00;
    end else begin
      unique case (s_reg.state)
        ENG_IDLE: begin
          if (start) begin
            // Hold capacitor is cut off from the pin for the whole conversion
            s_next.state = ENG_SETUP;
            s_next.hold = 1'b1;
            s_next.half = 5'h00;
            s_next.dac = 8'h00;
          end
        end
        ENG_SETUP: begin
          if (half_tick) begin
            if (s_reg.half == SETUP_HALVES - 5'h01) begin
              s_next.state = ENG_CONVERT;
              s_next.half = 5'h00;
              s_next.bit_idx = 3'h7;
              s_next.dac = bit_mask(3'h7);
            end else begin
              s_next.half = s_reg.half + 5'h01;
            end
          end
        end
        ENG_CONVERT: begin
          if (half_tick) begin
            if (s_reg.half == 5'h00) begin
              // First half lets the trial level settle
              s_next.half = 5'h01;
            end else if (s_reg.settle == SETTLE_CLKS) begin
              // The divide-by-2 clock stretches the bit period until the level is fresh
              s_next.half = 5'h00;
              s_next.dac = s_reg.cmp_level ? s_reg.dac : (s_reg.dac & ~bit_mask(s_reg.bit_idx));
              if (s_reg.bit_idx == 3'h0) begin
                s_next.state = ENG_FINISH;
              end else begin
                s_next.bit_idx = s_reg.bit_idx - 3'h1;
                s_next.dac = s_next.dac | bit_mask(s_reg.bit_idx - 3'h1);
              end
            end
          end
        end
        ENG_FINISH: begin
          if (half_tick) begin
            // Last half period closes the conversion, 9.5 bit periods except on the divide-by-2 clock
            s_next.state = ENG_IDLE;
            s_next.result = s_reg.dac;
            s_next.done = 1'b1;
            s_next.hold = 1'b0;
          end
        end
        default: begin
          s_next.state = ENG_IDLE;
          s_next.hold = 1'b0;
        end
      endcase
    end
    // Synchroniser lags the trial code, so decisions wait for it
    if (s_next.dac != s_reg.dac) begin
      s_next.settle = 3'h0;
    end else if (s_reg.settle != SETTLE_CLKS) begin
      s_next.settle = s_reg.settle + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_reg <= '{state: ENG_IDLE, result: RESULT_RESET, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign dac_code = s_reg.dac;
  assign sample_hold_open = s_reg.hold;
  assign busy = s_reg.state != ENG_IDLE;
  assign done = s_reg.done;
  assign result = s_reg.result;

endmodule : sar_engine
`default_nettype wire

// ### sar_adc_control_asserts.sv
// Port-level properties of the converter control block.
// Bound to sar_adc_control; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Status
  input wire logic special_event_trigger,
  input wire logic sample_hold_open,
  input wire logic [2:0] input_channel_select,
  input wire logic [3:0] analog_pin_enable,
  input wire logic converter_on,
  input wire logic conversion_done_flag,
  input wire logic conversion_done_pulse
);
  import sar_adc_pkg::*;
  logic [9:0] hold_cnt_reg;
  logic [9:0] hold_cnt_next;
  logic hold_prev_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Length of the latest hold window, kept after it closes
  always_comb begin
    hold_cnt_next = hold_cnt_reg;
    if (sample_hold_open) hold_cnt_next = hold_prev_reg ? hold_cnt_reg + 10'h001 : 10'h001;
  end
  always_ff @(posedge sys_clk) begin
    hold_cnt_reg <= nrst ? hold_cnt_next : 10'h000;
    hold_prev_reg <= nrst ? sample_hold_open : 1'b0;
  end
  a_reset_state: assert property (
    $rose(nrst) |-> !converter_on && !sample_hold_open && !conversion_done_flag
      && analog_pin_enable == 4'hF) else $error("state not cleared by reset");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
  a_bit1_zero: assert property (
    reg_rd && reg_addr == CTRL_ADDR |=> !reg_rdata[1]) else $error("bit 1 reads one");
  a_chan_resv: assert property (
    !input_channel_select[2]) else $error("reserved channel on output");
  a_go_reads: assert property (
    (sample_hold_open [*2] ##0 (reg_rd && reg_addr == CTRL_ADDR)) ##1 sample_hold_open
      |-> reg_rdata[GO_BIT]) else $error("start bit low during conversion");
  a_pulse_single: assert property (
    conversion_done_pulse |=> !conversion_done_pulse) else $error("done pulse too long");
  a_pulse_flag: assert property (
    conversion_done_pulse |-> ##[0:1] conversion_done_flag) else $error("flag not set");
  a_pulse_close: assert property (
    conversion_done_pulse |-> ##[0:2] !sample_hold_open) else $error("hold stays open");
  a_conv_len: assert property (
    conversion_done_pulse |-> hold_cnt_reg >= 10'h013) else $error("conversion too short");
  a_off_abort: assert property (
    $fell(converter_on) |-> ##[0:3] !sample_hold_open) else $error("no abort when off");
  a_trig_off: assert property (
    special_event_trigger && !converter_on && !sample_hold_open |=> !sample_hold_open [*3])
    else $error("trigger honoured while off");
  c_done: cover property (conversion_done_pulse);
  c_trig: cover property (special_event_trigger && converter_on);
  c_abort: cover property ($fell(converter_on) && sample_hold_open);
endmodule : sar_adc_control_asserts
bind sar_adc_control sar_adc_control_asserts i_chk (.sys_clk(sys_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .special_event_trigger(special_event_trigger), .sample_hold_open(sample_hold_open),
  .input_channel_select(input_channel_select), .analog_pin_enable(analog_pin_enable),
  .converter_on(converter_on), .conversion_done_flag(conversion_done_flag),
  .conversion_done_pulse(conversion_done_pulse));
`default_nettype wire

// ### sar_analog_model.sv
// Analog side model: channel levels, hold capacitor, comparator, RC clock.
// Assumes the trial code settles well within one system clock.
`timescale 1ns/1ns
`default_nettype none
module sar_analog_model #(
  parameter int RC_HALF_NS = 37
) (
  // Levels of the four inputs
  input wire logic [31:0] chan_levels,
  // Converter side
  input wire logic [7:0] dac_code,
  input wire logic sample_hold_open,
  input wire logic [2:0] input_channel_select,
  output logic comparator_out,
  output var logic rc_osc_in
);
  logic [7:0] held = 8'h00;
  // Oscillator runs free, also in sleep
  initial begin
    rc_osc_in = 1'b0;
    forever #(RC_HALF_NS) rc_osc_in = ~rc_osc_in;
  end
  always @(posedge sample_hold_open) held = chan_levels[input_channel_select[1:0] * 8 +: 8];
  assign comparator_out = held >= dac_code;
endmodule : sar_analog_model
`default_nettype wire

// ### sar_adc_control_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the analog model answers the comparator within a clock.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control_tb_top;
  import sar_adc_pkg::*;
  logic sys_clk, nrst, reg_wr, reg_rd, device_sleep, special_event_trigger, comparator_out;
  logic rc_osc_in, sample_hold_open, ref_external_sel, converter_on;
  logic conversion_done_flag, conversion_done_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, dac_code, d, lvl, v;
  logic [3:0] compare_mode_select, analog_pin_enable;
  logic [2:0] input_channel_select;
  logic [31:0] chan_levels;
  int failures, checks, seed, n;
  sar_adc_control i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .device_sleep(device_sleep), .compare_mode_select(compare_mode_select),
    .special_event_trigger(special_event_trigger), .comparator_out(comparator_out),
    .rc_osc_in(rc_osc_in), .dac_code(dac_code), .sample_hold_open(sample_hold_open),
    .input_channel_select(input_channel_select), .ref_external_sel(ref_external_sel),
    .analog_pin_enable(analog_pin_enable), .converter_on(converter_on),
    .conversion_done_flag(conversion_done_flag),
    .conversion_done_pulse(conversion_done_pulse));
  sar_analog_model i_model (.chan_levels(chan_levels), .dac_code(dac_code),
    .sample_hold_open(sample_hold_open), .input_channel_select(input_channel_select),
    .comparator_out(comparator_out), .rc_osc_in(rc_osc_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Pin config code to {reference pin, analog pins}
  function automatic logic [7:0] pin_exp(input logic [2:0] k);
    logic [7:0] t [8] = '{8'h0F, 8'h17, 8'h03, 8'h13, 8'h01, 8'h11, 8'h00, 8'h00};
    return t[k];
  endfunction : pin_exp
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic trig();
    @(posedge sys_clk);
    special_event_trigger <= 1'b1;
    @(posedge sys_clk);
    special_event_trigger <= 1'b0;
  endtask : trig
  // Bounded wait for the done pulse
  task automatic wait_done(input int lim, input logic exp);
    int k;
    k = 0;
    while (conversion_done_pulse !== 1'b1 && k < lim) begin
      @(posedge sys_clk);
      #1 k++;
    end
    chk("done", {7'h00, k < lim}, {7'h00, exp});
  endtask : wait_done
  // Enable, start by write or trigger, then check result, start bit and flag
  task automatic conv(input logic [1:0] cs, input logic by_trig);
    lvl = 8'($random(seed));
    n = $unsigned($random(seed)) % 4;
    chan_levels[n * 8 +: 8] = lvl;
    v = {cs, 1'b0, n[1:0], 3'h1};
    wr(CTRL_ADDR, v);
    if (by_trig) trig();
    else wr(CTRL_ADDR, v | 8'h04);
    wait_done(1200, 1'b1);
    rd(RESULT_ADDR);
    chk("result", d, lvl);
    rd(CTRL_ADDR);
    chk("ctrl_go", d, v);
    rd(FLAG_ADDR);
    chk("flag", d, 8'h40);
    chk("flag_pin", {7'h00, conversion_done_flag}, 8'h01);
    wr(FLAG_ADDR, 8'h00);
    #1 chk("flag_clr", {7'h00, conversion_done_flag}, 8'h00);
  endtask : conv
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    conclude();
  end
  initial begin
    {nrst, reg_wr, reg_rd, device_sleep, special_event_trigger} = 5'h00;
    {reg_addr, reg_wdata, chan_levels} = 48'h0;
    compare_mode_select = TRIGGER_MODE;
    seed = 49;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(CTRL_ADDR);
    chk("ctrl_rst", d, 8'h00);
    rd(PINCFG_ADDR);
    chk("pin_rst", {ref_external_sel, analog_pin_enable}, 8'h0F);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 8'(($random(seed) & 8'h18) | (i << 6));
      wr(CTRL_ADDR, v | 8'h02);
      rd(CTRL_ADDR);
      chk("ctrl_rb", d, v);
      chk("chan", {5'h00, input_channel_select}, {6'h00, v[4:3]});
    end
    wr(CTRL_ADDR, 8'h38);
    #1 chk("chan_resv", {5'h00, input_channel_select}, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55);
    chk("unmapped", d, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(PINCFG_ADDR, k[7:0]);
      #1 chk("pins", {ref_external_sel, analog_pin_enable}, pin_exp(k[2:0]));
    end
    $display("test registers done");
    for (int c = 0; c < 4; c++) conv(c[1:0], 1'b0);
    conv(CLK_DIV8, 1'b1);
    compare_mode_select <= 4'h0;
    trig();
    wait_done(100, 1'b0);
    compare_mode_select <= TRIGGER_MODE;
    wr(CTRL_ADDR, 8'h00);
    trig();
    wait_done(100, 1'b0);
    $display("test conversions done");
    device_sleep <= 1'b1;
    wr(CTRL_ADDR, 8'h41);
    wr(CTRL_ADDR, 8'h45);
    wait_done(150, 1'b0);
    device_sleep <= 1'b0;
    wait_done(1200, 1'b1);
    wr(FLAG_ADDR, 8'h00);
    device_sleep <= 1'b1;
    conv(CLK_RC, 1'b0);
    device_sleep <= 1'b0;
    $display("test sleep done");
    wr(CTRL_ADDR, 8'h81);
    wr(CTRL_ADDR, 8'h85);
    repeat (30) @(posedge sys_clk);
    rd(CTRL_ADDR);
    chk("go_busy", d, 8'h85);
    wr(CTRL_ADDR, 8'h80);
    wait_done(600, 1'b0);
    rd(RESULT_ADDR);
    chk("res_kept", d, lvl);
    wr(CTRL_ADDR, 8'h81);
    wr(CTRL_ADDR, 8'h85);
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("on_rst", {6'h00, converter_on, sample_hold_open}, 8'h00);
    chk("dac_rst", dac_code, 8'h00);
    rd(RESULT_ADDR);
    chk("res_rst", d, RESULT_RESET);
    $display("test abort done");
    conclude();
  end
endmodule : sar_adc_control_tb_top
`default_nettype wire
